// file: ccd_clock_config_decode.sv
// reference divider trim control and boot configuration decode with apb access
// Overview of operation
// - nine-bit trim adds n/512 to divider
// - trim change waits for switch go while module on
// - divider change waits for switch go while module on
// - run-in-sleep ignored for two lowest sources
// - unimplemented bits read as zero
// - switch/monitor field decodes both enables
// - peripheral bus divisor 1,2,4,8
// - primary oscillator mode decode
// - two-speed startup bit enables it
// - secondary oscillator enable at load
// - initial source selection decode
// - pll output divisor 1 to 256
// - usb pll enable is active low
// - usb pll input divider decode
// - main pll multiplier decode
// - main pll input divider decode
// - go bit clears when switch completes
// - module off: divider writes apply directly
`timescale 1ns/10ps
`default_nettype none
`include "ccd_regs.svh"

module ccd_clock_config_decode
(
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile words seen at power-on
  input wire logic [31:0] cfgWord1In,
  input wire logic [31:0] cfgWord2In,
  // reference generator handshake
  input wire logic refBoundary,
  input wire logic refRequestActive,
  input wire logic sleepMode,
  // results
  output ccd_pkg::ccd_cfg_s cfgOut,
  output ccd_pkg::ccd_ref_s refOut,
  output logic cfgValid
);

  // ---------------------------------------------
  // storage
  // ---------------------------------------------
  logic [31:0] word1_r; // captured boot word one
  logic [31:0] word2_r; // captured boot word two
  ccd_pkg::ccd_load_e loadState_r; // load sequence
  logic onBit_r; // module enable
  logic sleepRun_r; // run-in-sleep
  logic go_r; // divider switch go
  logic [3:0] sel_r; // source select
  logic [14:0] pendDiv_r; // divider as written
  logic [8:0] pendTrim_r; // trim as written
  logic [14:0] actDiv_r; // divider in use
  logic [8:0] actTrim_r; // trim in use
  logic accessDone; // apb access completes this edge
  logic wrCtrl; // control word written
  logic wrTrim; // trim word written
  logic applyNow; // pending values move to active
  logic mapped; // address hits a register
  logic [31:0] rdMux; // read value

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  assign accessDone = psel && penable && pready;
  assign wrCtrl = accessDone && pwrite && paddr == `CCD_OFF_CTRL;
  assign wrTrim = accessDone && pwrite && paddr == `CCD_OFF_TRIM;
  assign mapped = paddr == `CCD_OFF_CTRL || paddr == `CCD_OFF_TRIM ||
    paddr == `CCD_OFF_CFG1 || paddr == `CCD_OFF_CFG2;
  // switch only on a boundary of the running reference clock
  assign applyNow = onBit_r && go_r && refBoundary;

  // read mux, unused positions forced low
  always_comb
  begin
    rdMux = 32'h00000000;
    case (paddr)
      `CCD_OFF_CTRL:
      begin
        rdMux[`CCD_CTRL_DIV_LSB +: 15] = pendDiv_r;
        rdMux[`CCD_CTRL_ON] = onBit_r;
        rdMux[`CCD_CTRL_SLEEP_RUN] = sleepRun_r;
        rdMux[`CCD_CTRL_GO] = go_r;
        rdMux[`CCD_CTRL_ACT] = refRequestActive;
        rdMux[`CCD_CTRL_SEL_LSB +: 4] = sel_r;
      end
      `CCD_OFF_TRIM: rdMux[`CCD_TRIM_LSB +: 9] = pendTrim_r;
      `CCD_OFF_CFG1: rdMux = word1_r;
      `CCD_OFF_CFG2: rdMux = word2_r;
      default: rdMux = 32'h00000000;
    endcase
  end

  // one wait state so that answers come from flops
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h00000000 : rdMux;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------
  // reference control
  // ---------------------------------------------
  // plain control bits
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      onBit_r <= 1'b0;
      sleepRun_r <= 1'b0;
      sel_r <= `CCD_SEL_RST;
    end
    else if (wrCtrl)
    begin
      onBit_r <= pwdata[`CCD_CTRL_ON];
      sleepRun_r <= pwdata[`CCD_CTRL_SLEEP_RUN];
      sel_r <= pwdata[`CCD_CTRL_SEL_LSB +: 4];
    end
  end

  // go bit, a software set wins over the hardware clear
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      go_r <= 1'b0;
    else if (wrCtrl && pwdata[`CCD_CTRL_GO])
      go_r <= 1'b1;
    else if (applyNow || !onBit_r)
      go_r <= 1'b0;
  end

  // values as written by software
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pendDiv_r <= `CCD_DIV_RST;
      pendTrim_r <= `CCD_TRIM_RST;
    end
    else
    begin
      if (wrCtrl)
        pendDiv_r <= pwdata[`CCD_CTRL_DIV_LSB +: 15];
      if (wrTrim)
        pendTrim_r <= pwdata[`CCD_TRIM_LSB +: 9];
    end
  end

  // active values: direct while off, together on a boundary while on
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      actDiv_r <= `CCD_DIV_RST;
      actTrim_r <= `CCD_TRIM_RST;
    end
    else if (!onBit_r)
    begin
      // off: follow every write at once
      if (wrCtrl)
        actDiv_r <= pwdata[`CCD_CTRL_DIV_LSB +: 15];
      if (wrTrim)
        actTrim_r <= pwdata[`CCD_TRIM_LSB +: 9];
    end
    else if (applyNow)
    begin
      // on: both move in one step
      actDiv_r <= pendDiv_r;
      actTrim_r <= pendTrim_r;
    end
  end

  // reference outputs
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      refOut <= '0;
    else
    begin
      refOut.enable <= onBit_r;
      // sleep keeps it running only for sources other than the two bus clocks
      refOut.runGate <= onBit_r && (!sleepMode || (sleepRun_r && sel_r > 4'h1));
      refOut.source <= sel_r;
      refOut.intDiv <= actDiv_r;
      refOut.trim <= actTrim_r;
      // divisor in 1/512 steps: 2*(div + trim/512), the trim adds to the divider value
      refOut.fixedDiv <= {actDiv_r, actTrim_r, 1'b0};
    end
  end

  // ---------------------------------------------
  // boot configuration
  // ---------------------------------------------
  // capture once after reset release, then decode
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      loadState_r <= ccd_pkg::LD_CAPTURE;
      word1_r <= `CCD_CFG_ERASED;
      word2_r <= `CCD_CFG_ERASED;
      cfgValid <= 1'b0;
    end
    else
    begin
      case (loadState_r)
        ccd_pkg::LD_CAPTURE:
        begin
          word1_r <= cfgWord1In;
          word2_r <= cfgWord2In;
          loadState_r <= ccd_pkg::LD_DECODE;
        end
        ccd_pkg::LD_DECODE:
        begin
          cfgValid <= 1'b1;
          loadState_r <= ccd_pkg::LD_DONE;
        end
        ccd_pkg::LD_DONE: loadState_r <= ccd_pkg::LD_DONE;
        default: loadState_r <= ccd_pkg::LD_CAPTURE;
      endcase
    end
  end

  // divider table shared by both pll input dividers
  function automatic logic [3:0] inDiv(input logic [2:0] code);
    case (code)
      3'h6: inDiv = 4'ha;
      3'h7: inDiv = 4'hc;
      default: inDiv = 4'(code) + 4'h1;
    endcase
  endfunction

  // field decode from the captured words
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      cfgOut <= '0;
    else
    begin
      cfgOut.switchEn <= !word1_r[`CCD_C1_SWMON_LSB + 1];
      cfgOut.monitorEn <= word1_r[`CCD_C1_SWMON_LSB +: 2] == 2'h0;
      cfgOut.pbDivRatio <= 4'h1 << word1_r[`CCD_C1_PBDIV_LSB +: 2];
      case (word1_r[`CCD_C1_POSC_LSB +: 2])
        2'h0: cfgOut.poscMode <= ccd_pkg::POSC_EXT;
        2'h1: cfgOut.poscMode <= ccd_pkg::POSC_MEDIUM;
        2'h2: cfgOut.poscMode <= ccd_pkg::POSC_HIGH;
        default: cfgOut.poscMode <= ccd_pkg::POSC_OFF;
      endcase
      cfgOut.poscEn <= word1_r[`CCD_C1_POSC_LSB +: 2] != 2'h3;
      cfgOut.twoSpeedEn <= word1_r[`CCD_C1_TWOSPD];
      cfgOut.secOscEn <= word1_r[`CCD_C1_SOSC];
      cfgOut.initSource <= ccd_pkg::ccd_src_e'(word1_r[`CCD_C1_SRC_LSB +: 3]);
      case (word2_r[`CCD_C2_PLLODIV_LSB +: 3])
        3'h7: cfgOut.pllOutDiv <= 9'h100;
        default: cfgOut.pllOutDiv <= 9'h001 << word2_r[`CCD_C2_PLLODIV_LSB +: 3];
      endcase
      cfgOut.usbPllEn <= !word2_r[`CCD_C2_USBDIS];
      cfgOut.usbPllBypass <= word2_r[`CCD_C2_USBDIS];
      cfgOut.usbInDiv <= inDiv(word2_r[`CCD_C2_USBIDIV_LSB +: 3]);
      case (word2_r[`CCD_C2_MUL_LSB +: 3])
        3'h7: cfgOut.pllMul <= 5'h18;
        default: cfgOut.pllMul <= 5'(word2_r[`CCD_C2_MUL_LSB +: 3]) + 5'h0f;
      endcase
      cfgOut.pllInDiv <= inDiv(word2_r[`CCD_C2_IDIV_LSB +: 3]);
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_trim_low_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    psel && penable && pready && !pwrite && paddr == `CCD_OFF_TRIM |-> prdata[22:0] == 23'h0)
    else $error("trim low bits not zero");

  a_div_held_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    onBit_r && !go_r |=> $stable(actDiv_r))
    else $error("divider changed without go");

  a_trim_held_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    onBit_r && !go_r |=> $stable(actTrim_r))
    else $error("trim changed without go");

  a_switch_done: assert property (@(posedge clk_sys) disable iff (!nrst)
    applyNow && !wrCtrl |=> !go_r && actDiv_r == $past(pendDiv_r) && actTrim_r == $past(pendTrim_r))
    else $error("switch did not complete");

  a_off_direct: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrCtrl && !onBit_r |=> actDiv_r == $past(pwdata[30:16]))
    else $error("divider not applied while off");

  a_boundary_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    onBit_r && $past(onBit_r) && $changed(actDiv_r) |-> $past(refBoundary) && $past(go_r))
    else $error("divider moved off boundary");

  a_sleep_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
    sleepMode && sel_r < 4'h2 |=> !refOut.runGate)
    else $error("run-in-sleep honoured for bus clock source");

  a_swmon_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgValid |-> cfgOut.switchEn == !word1_r[15] && cfgOut.monitorEn == (word1_r[15:14] == 2'h0))
    else $error("switch monitor decode wrong");

  a_pbdiv_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgValid |-> $onehot(cfgOut.pbDivRatio) && cfgOut.pbDivRatio[word1_r[13:12]])
    else $error("bus divisor decode wrong");

  a_usb_pll: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgValid |-> cfgOut.usbPllEn != word2_r[15] && cfgOut.usbPllBypass == word2_r[15])
    else $error("usb pll enable polarity wrong");

  a_ctrl_unused_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    psel && penable && pready && !pwrite && paddr == `CCD_OFF_CTRL |->
    !prdata[31] && prdata[14:12] == 3'h0 && !prdata[10] && prdata[7:4] == 4'h0)
    else $error("control word unused bits not zero");

  a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst)
    psel && penable && pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
    else $error("error response does not match address map");

  a_boot_held: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgValid |=> $stable(cfgOut))
    else $error("boot decode changed after load");

endmodule
`default_nettype wire

// file: ccd_pkg.sv
// types shared by the clock configuration block
package ccd_pkg;
  // primary oscillator mode
  typedef enum logic [1:0] {POSC_EXT, POSC_MEDIUM, POSC_HIGH, POSC_OFF} ccd_posc_e;
  // initial clock source
  typedef enum logic [2:0] {SRC_FAST_RC, SRC_FAST_RC_PLL, SRC_PRI, SRC_PRI_PLL, SRC_SEC,
    SRC_LOW_POWER_RC, SRC_FAST_RC_DIV16, SRC_FAST_RC_DIVN} ccd_src_e;
  // configuration load sequence
  typedef enum logic [1:0] {LD_CAPTURE, LD_DECODE, LD_DONE} ccd_load_e;
  // decoded boot configuration
  typedef struct packed {
    logic switchEn;
    logic monitorEn;
    logic [3:0] pbDivRatio;
    ccd_posc_e poscMode;
    logic poscEn;
    logic twoSpeedEn;
    logic secOscEn;
    ccd_src_e initSource;
    logic [8:0] pllOutDiv;
    logic usbPllEn;
    logic usbPllBypass;
    logic [3:0] usbInDiv;
    logic [4:0] pllMul;
    logic [3:0] pllInDiv;
  } ccd_cfg_s;
  // active reference divider state
  typedef struct packed {
    logic enable;
    logic runGate;
    logic [3:0] source;
    logic [14:0] intDiv;
    logic [8:0] trim;
    logic [24:0] fixedDiv;
  } ccd_ref_s;
endpackage

// file: ccd_regs.svh
// register offsets, field positions and reset values of the clock configuration block
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
// apb byte offsets
`define CCD_OFF_CTRL 8'h00
`define CCD_OFF_TRIM 8'h04
`define CCD_OFF_CFG1 8'h08
`define CCD_OFF_CFG2 8'h0c
// reference control word fields
`define CCD_CTRL_DIV_LSB 16
`define CCD_CTRL_ON 15
`define CCD_CTRL_SLEEP_RUN 11
`define CCD_CTRL_GO 9
`define CCD_CTRL_ACT 8
`define CCD_CTRL_SEL_LSB 0
// trim word field
`define CCD_TRIM_LSB 23
// boot word one fields
`define CCD_C1_SWMON_LSB 14
`define CCD_C1_PBDIV_LSB 12
`define CCD_C1_POSC_LSB 8
`define CCD_C1_TWOSPD 7
`define CCD_C1_SOSC 5
`define CCD_C1_SRC_LSB 0
// boot word two fields
`define CCD_C2_PLLODIV_LSB 16
`define CCD_C2_USBDIS 15
`define CCD_C2_USBIDIV_LSB 8
`define CCD_C2_MUL_LSB 4
`define CCD_C2_IDIV_LSB 0
// reset values
`define CCD_CFG_ERASED 32'hffffffff
`define CCD_DIV_RST 15'h0000
`define CCD_TRIM_RST 9'h000
`define CCD_SEL_RST 4'h0
`endif

// file: tb.sv
// self-checking bench for the clock configuration decode block
`timescale 1ns/10ps
`default_nettype none
`include "ccd_regs.svh"

module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys; // 40 mhz system clock
  logic nrst; // synchronous reset, active low
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, w1, w2;
  logic [31:0] cfgWord1In, cfgWord2In;
  logic refBoundary, refRequestActive, sleepMode, cfgValid;
  ccd_pkg::ccd_cfg_s cfgOut;
  ccd_pkg::ccd_ref_s refOut;
  logic [14:0] divA, divB; // integer divider values
  logic [8:0] trimA, trimB; // fraction trim values
  int seed = 32'hd176; // fixed seed
  int n_fail = 0;
  int compares = 0;

  ccd_clock_config_decode u_ccd_clock_config_decode (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfgWord1In(cfgWord1In),
    .cfgWord2In(cfgWord2In), .refBoundary(refBoundary), .refRequestActive(refRequestActive),
    .sleepMode(sleepMode), .cfgOut(cfgOut), .refOut(refOut), .cfgValid(cfgValid));

  // clock, 25 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // verdict and end of run
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one comparison
  task chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one apb transfer, entered right after a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      n_fail++; // answer never came
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys); // idle cycle keeps back-to-back transfers apart
  endtask

  // reset held for 12 cycles, then settle
  task rst_seq;
    nrst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  // input divider code to ratio
  function automatic logic [3:0] idiv(input logic [2:0] c);
    return (c == 3'h6) ? 4'ha : (c == 3'h7) ? 4'hc : {1'b0, c} + 4'h1;
  endfunction

  // expected decode of both boot words
  function automatic ccd_pkg::ccd_cfg_s dec(input logic [31:0] a, input logic [31:0] b);
    ccd_pkg::ccd_cfg_s c;
    c.switchEn = ~a[15];
    c.monitorEn = (a[15:14] == 2'h0);
    c.pbDivRatio = 4'h1 << a[13:12];
    c.poscMode = ccd_pkg::ccd_posc_e'(a[9:8]);
    c.poscEn = (a[9:8] != 2'h3);
    c.twoSpeedEn = a[7];
    c.secOscEn = a[5];
    c.initSource = ccd_pkg::ccd_src_e'(a[2:0]);
    c.pllOutDiv = (b[18:16] == 3'h7) ? 9'h100 : 9'h001 << b[18:16];
    c.usbPllEn = ~b[15];
    c.usbPllBypass = b[15];
    c.usbInDiv = idiv(b[10:8]);
    c.pllMul = (b[6:4] == 3'h7) ? 5'h18 : 5'h0f + {2'h0, b[6:4]};
    c.pllInDiv = idiv(b[2:0]);
    return c;
  endfunction

  // control word builder
  function automatic logic [31:0] ctl(input logic [14:0] dv, input logic on,
    input logic slp, input logic go, input logic [3:0] sel);
    return {1'b0, dv, on, 3'h0, slp, 1'b0, go, 1'b0, 4'h0, sel};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, refBoundary, refRequestActive, sleepMode} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    nrst = 1'b0;
    cfgWord1In = 32'h0;
    cfgWord2In = 32'h0;
    // boot decode: corners then random words
    for (int k = 0; k < 24; k++)
    begin
      w1 = (k == 0) ? 32'h0 : (k == 1) ? 32'hffffffff : $random(seed);
      w2 = (k == 0) ? 32'h0 : (k == 1) ? 32'hffffffff : $random(seed);
      // primary oscillator stays on when it is the initial source
      if (w1[9:8] == 2'h3 && w1[2:1] == 2'h1)
        w1[8] = 1'b0;
      cfgWord1In <= w1;
      cfgWord2In <= w2;
      rst_seq();
      cfgWord1In <= ~w1; // later changes are ignored
      apb(1'b1, `CCD_OFF_CFG1, 32'h0); // boot word write is ignored
      chk(cfgValid, 1'b1);
      chk(cfgOut, dec(w1, w2));
      // boot words read back as captured
      apb(1'b0, `CCD_OFF_CFG1, 32'h0);
      chk(rd, w1);
      apb(1'b0, `CCD_OFF_CFG2, 32'h0);
      chk(rd, w2);
    end
    // reset values and status readback
    apb(1'b0, `CCD_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    refRequestActive <= 1'b1;
    apb(1'b0, `CCD_OFF_CTRL, 32'h0);
    chk(rd, 32'h100);
    refRequestActive <= 1'b0;
    // module off: values apply directly
    divA = 15'($random(seed));
    trimA = 9'($random(seed));
    apb(1'b1, `CCD_OFF_TRIM, {trimA, 23'h7fffff});
    apb(1'b0, `CCD_OFF_TRIM, 32'h0);
    chk(rd, {trimA, 23'h0});
    apb(1'b1, `CCD_OFF_CTRL, ctl(divA, 1'b0, 1'b1, 1'b0, 4'h3) | 32'h80004400);
    apb(1'b0, `CCD_OFF_CTRL, 32'h0);
    chk(rd, ctl(divA, 1'b0, 1'b1, 1'b0, 4'h3));
    repeat (3) @(posedge clk_sys);
    chk(refOut.fixedDiv, {divA, trimA, 1'b0});
    // module on: new values wait for the switch
    apb(1'b1, `CCD_OFF_CTRL, ctl(divA, 1'b1, 1'b0, 1'b0, 4'h3));
    repeat (3) @(posedge clk_sys);
    chk(refOut.enable, 1'b1);
    divB = ~divA;
    trimB = ~trimA;
    apb(1'b1, `CCD_OFF_TRIM, {trimB, 23'h0});
    apb(1'b1, `CCD_OFF_CTRL, ctl(divB, 1'b1, 1'b0, 1'b0, 4'h3));
    refBoundary <= 1'b1; // boundary without go changes nothing
    @(posedge clk_sys);
    refBoundary <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(refOut.intDiv, divA);
    chk(refOut.trim, trimA);
    apb(1'b1, `CCD_OFF_CTRL, ctl(divB, 1'b1, 1'b0, 1'b1, 4'h3));
    apb(1'b0, `CCD_OFF_CTRL, 32'h0);
    chk(rd[9], 1'b1);
    repeat (3) @(posedge clk_sys);
    chk(refOut.fixedDiv, {divA, trimA, 1'b0});
    refBoundary <= 1'b1;
    @(posedge clk_sys);
    refBoundary <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(refOut.fixedDiv, {divB, trimB, 1'b0});
    apb(1'b0, `CCD_OFF_CTRL, 32'h0);
    chk(rd[9], 1'b0);
    // run in sleep against each low source code
    sleepMode <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `CCD_OFF_CTRL, ctl(divB, 1'b1, 1'b1, 1'b0, s[3:0]));
      repeat (3) @(posedge clk_sys);
      chk(refOut.runGate, s > 1);
      chk(refOut.source, s[3:0]);
    end
    apb(1'b1, `CCD_OFF_CTRL, ctl(divB, 1'b1, 1'b0, 1'b0, 4'h2));
    repeat (3) @(posedge clk_sys);
    chk(refOut.runGate, 1'b0);
    sleepMode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(refOut.runGate, 1'b1);
    // unmapped address
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    wrap_up();
  end
endmodule
`default_nettype wire
